// *** rtl/swc_sleep_wake.sv ***
// Sleep/wake controller: halt entry, no-op decision, watchdog clearing,
// timeout and power-down flags. Assumes the sequencer pulses haltReq for
// one cycle and the watchdog obeys wdtClear within one cycle.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - Every exit from halt clears the watchdog, whatever woke the device.
// - Global enable clear and pending enabled flag before halt: halt runs as no-op.
// - No-op halt keeps watchdog counts, leaves timeout and power-down flags.
// - Enabled flag during or after halt wakes device after halt completes.
// - Completed halt clears watchdog, sets timeout, clears power-down.
// - Interrupt wakes only with source enable set, whatever global enable says.
// - After wake, run next instruction, then vector only if global enable set.
// - Power-down flag set at power-up, cleared on halt; watchdog wake with no enabled flag pending clears timeout.
module swc_sleep_wake
    import swc_pkg::*;
#(
    parameter int NSRC = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clkEn,
    // Sequencer side
    input wire logic haltReq,
    output logic haltDone,
    output logic haltNop,
    output logic halted,
    output logic resumeNext,
    output logic vectorReq,
    output logic [12:0] vectorAddr,
    // Interrupt sources, from pins (asynchronous)
    input wire logic [NSRC-1:0] srcFlagIn,
    // Watchdog
    input wire logic wdtTimeout,
    output logic wdtClear,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [NSRC-1:0] flagMeta_ff;
    logic [NSRC-1:0] flagSync_ff;
    logic wdtMeta_ff;
    logic wdtSync_ff;

    // Two stages for each asynchronous input
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            flagMeta_ff <= '0;
            flagSync_ff <= '0;
            wdtMeta_ff <= 1'b0;
            wdtSync_ff <= 1'b0;
        end else if (clkEn) begin
            flagMeta_ff <= srcFlagIn;
            flagSync_ff <= flagMeta_ff;
            wdtMeta_ff <= wdtTimeout;
            wdtSync_ff <= wdtMeta_ff;
        end
    end

    // ----------------------------------------
    // Registers and decode
    // ----------------------------------------
    logic globalEn_ff;
    logic [NSRC-1:0] srcEn_ff;
    logic timeoutFlag_ff;
    logic powerDownFlag_ff;
    logic [IRQ_WIDTH-1:0] irqStat_ff;
    logic [IRQ_WIDTH-1:0] irqMask_ff;
    logic [IRQ_WIDTH-1:0] irqEvent;
    logic wrEn;
    logic rdEn;
    logic addrOk;
    logic pendingWake;
    swc_state_type state_ff;

    assign wrEn = psel && penable && pwrite && clkEn;
    // Read data is loaded in the setup phase so it stands through the access phase
    assign rdEn = psel && !penable && !pwrite && clkEn;
    assign addrOk = (paddr == REG_CTRL) || (paddr == REG_STAT) || (paddr == REG_IRQ_STAT)
        || (paddr == REG_IRQ_MASK) || (paddr == REG_SRC_EN) || (paddr == REG_SRC_FLAG);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrOk;

    // Enabled flagged source, global enable ignored
    assign pendingWake = |(flagSync_ff & srcEn_ff);

    // Software-written control
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            globalEn_ff <= RST_GLOBAL_EN;
            srcEn_ff <= '0;
            irqMask_ff <= '0;
        end else if (wrEn) begin
            if (paddr == REG_CTRL) begin
                globalEn_ff <= pwdata[CTRL_GLOBAL_EN_BIT];
            end
            if (paddr == REG_SRC_EN) begin
                srcEn_ff <= pwdata[NSRC-1:0];
            end
            if (paddr == REG_IRQ_MASK) begin
                irqMask_ff <= pwdata[IRQ_WIDTH-1:0];
            end
        end
    end

    // Read data mux, registered at the setup edge
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (rdEn) begin
            unique case (paddr)
                REG_CTRL: prdata <= {31'h0000_0000, globalEn_ff};
                REG_STAT: prdata <= {29'h0000_0000, (state_ff == ST_HALT), powerDownFlag_ff,
                    timeoutFlag_ff};
                REG_IRQ_STAT: prdata <= {29'h0000_0000, irqStat_ff};
                REG_IRQ_MASK: prdata <= {29'h0000_0000, irqMask_ff};
                REG_SRC_EN: prdata <= {{(32-NSRC){1'b0}}, srcEn_ff};
                REG_SRC_FLAG: prdata <= {{(32-NSRC){1'b0}}, flagSync_ff};
                default: prdata <= PSLVERR_DATA;
            endcase
        end
    end

    // ----------------------------------------
    // Halt sequencing
    // ----------------------------------------
    // ST_ENTER is the cycle the halt instruction completes; ST_HALT waits.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_ff <= ST_RUN;
        end else if (clkEn) begin
            unique case (state_ff)
                ST_RUN: begin
                    if (haltReq && !pendingWake) begin
                        state_ff <= ST_ENTER;
                    end
                end
                ST_ENTER: begin
                    state_ff <= ST_HALT;
                end
                ST_HALT: begin
                    if (pendingWake || wdtSync_ff) begin
                        state_ff <= ST_RUN;
                    end
                end
                default: state_ff <= ST_RUN;
            endcase
        end
    end

    // Sequencer handshake and watchdog clear
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            haltDone <= 1'b0;
            haltNop <= 1'b0;
            wdtClear <= 1'b0;
            resumeNext <= 1'b0;
            vectorReq <= 1'b0;
            vectorAddr <= '0;
        end else if (clkEn) begin
            haltDone <= 1'b0;
            haltNop <= 1'b0;
            wdtClear <= 1'b0;
            resumeNext <= 1'b0;
            vectorReq <= 1'b0;
            if (state_ff == ST_RUN && haltReq && pendingWake) begin
                haltDone <= 1'b1;
                haltNop <= 1'b1;
            end
            if (state_ff == ST_ENTER) begin
                haltDone <= 1'b1;
                wdtClear <= 1'b1;
            end
            if (state_ff == ST_HALT && (pendingWake || wdtSync_ff)) begin
                wdtClear <= 1'b1;
                resumeNext <= 1'b1;
                vectorReq <= globalEn_ff && pendingWake;
                vectorAddr <= IRQ_VECTOR;
            end
        end
    end
    assign halted = (state_ff == ST_HALT);

    // Timeout and power-down flags
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            timeoutFlag_ff <= RST_TIMEOUT;
            powerDownFlag_ff <= RST_PWRDN;
        end else if (clkEn) begin
            if (state_ff == ST_ENTER) begin
                timeoutFlag_ff <= 1'b1;
                powerDownFlag_ff <= 1'b0;
            end else if (state_ff == ST_HALT && wdtSync_ff && !pendingWake) begin
                timeoutFlag_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Interrupt status, write one to clear
    // ----------------------------------------
    assign irqEvent[IRQ_WAKE_BIT] = clkEn && state_ff == ST_HALT && (pendingWake || wdtSync_ff);
    assign irqEvent[IRQ_NOP_BIT] = clkEn && state_ff == ST_RUN && haltReq && pendingWake;
    assign irqEvent[IRQ_WDT_BIT] = clkEn && state_ff == ST_HALT && wdtSync_ff;

    // Set wins over a same-cycle clear
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            irqStat_ff <= '0;
        end else begin
            for (int i = 0; i < IRQ_WIDTH; i++) begin
                if (irqEvent[i]) begin
                    irqStat_ff[i] <= 1'b1;
                end else if (wrEn && paddr == REG_IRQ_STAT && pwdata[i]) begin
                    irqStat_ff[i] <= 1'b0;
                end
            end
        end
    end
    assign irq = |(irqStat_ff & irqMask_ff);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_wake_clears_wdt: assert property (@(posedge sys_clk) disable iff (!rstn)
        (clkEn && state_ff == ST_HALT && (pendingWake || wdtSync_ff)) |=> wdtClear)
        else $error("wake without watchdog clear");
    a_nop_no_halt: assert property (@(posedge sys_clk) disable iff (!rstn)
        (clkEn && state_ff == ST_RUN && haltReq && pendingWake) |=> (haltNop && !halted))
        else $error("pending wake did not give no-op");
    a_nop_keeps_flags: assert property (@(posedge sys_clk) disable iff (!rstn)
        (clkEn && state_ff == ST_RUN && haltReq && pendingWake) |=>
            (!wdtClear && $stable(powerDownFlag_ff) && $stable(timeoutFlag_ff)))
        else $error("no-op halt disturbed watchdog or flags");
    a_wake_after_done: assert property (@(posedge sys_clk) disable iff (!rstn)
        (clkEn && state_ff == ST_RUN && haltReq && !pendingWake) |=> ##1 (haltDone && halted))
        else $error("halt did not complete before wake");
    a_halt_done_flags: assert property (@(posedge sys_clk) disable iff (!rstn)
        (clkEn && state_ff == ST_ENTER) |=> (wdtClear && timeoutFlag_ff && !powerDownFlag_ff))
        else $error("completed halt flags wrong");
    a_wake_needs_enable: assert property (@(posedge sys_clk) disable iff (!rstn)
        (clkEn && halted && !wdtSync_ff && !(|(flagSync_ff & srcEn_ff))) |=> halted)
        else $error("woke without enabled source");
    a_vector_global: assert property (@(posedge sys_clk) disable iff (!rstn)
        vectorReq |-> (resumeNext && globalEn_ff && vectorAddr == IRQ_VECTOR))
        else $error("vector without global enable");
    a_wdt_wake_to: assert property (@(posedge sys_clk) disable iff (!rstn)
        (clkEn && halted && wdtSync_ff && !pendingWake) |=> !timeoutFlag_ff)
        else $error("watchdog wake kept timeout flag");

endmodule : swc_sleep_wake

// *** rtl/swc_pkg.sv ***
// Constants for the sleep/wake controller.
// Assumes a single system clock and an APB register port.
package swc_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_SRC_EN = 8'h10;
    localparam logic [7:0] REG_SRC_FLAG = 8'h14;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_GLOBAL_EN_BIT = 0;
    localparam int STAT_TIMEOUT_BIT = 0;
    localparam int STAT_PWRDN_BIT = 1;
    localparam int STAT_HALT_BIT = 2;
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_NOP_BIT = 1;
    localparam int IRQ_WDT_BIT = 2;
    localparam int IRQ_WIDTH = 3;
    // ----------------------------------------
    // Reset values and interrupt vector
    // ----------------------------------------
    localparam logic RST_TIMEOUT = 1'b1;
    localparam logic RST_PWRDN = 1'b1;
    localparam logic RST_GLOBAL_EN = 1'b0;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [31:0] PSLVERR_DATA = 32'h0000_0000;
    // Controller states
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_ENTER = 3'b010,
        ST_HALT = 3'b100
    } swc_state_type;
endpackage : swc_pkg

// *** tb/sleep_wake_control_bench.sv ***
// Self-checking bench for the sleep/wake controller.
// Assumes swc_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin failCount++; \
    $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module sleep_wake_control_bench;
    import swc_pkg::*;
    // ----------------------------------------
    // Signals and design instance
    // ----------------------------------------
    logic sys_clk, rstn, clkEn, haltReq, wdtTimeout, psel, penable, pwrite;
    logic [7:0] srcFlagIn, paddr;
    logic [31:0] pwdata, prdata, rd;
    logic haltDone, haltNop, halted, resumeNext, vectorReq, wdtClear, pready, pslverr, irq, err;
    logic [12:0] vectorAddr;
    int failCount = 0;
    int nCompared = 0;
    swc_sleep_wake #(.NSRC(8)) dut (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .haltReq(haltReq),
        .haltDone(haltDone), .haltNop(haltNop), .halted(halted), .resumeNext(resumeNext),
        .vectorReq(vectorReq), .vectorAddr(vectorAddr), .srcFlagIn(srcFlagIn), .wdtTimeout(wdtTimeout),
        .wdtClear(wdtClear), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    // ----------------------------------------
    // Clock, verdict and watchdog
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task test_done;
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (3000) @(posedge sys_clk);
        failCount++;
        test_done;
    end
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    // One APB transfer; waits for pready at the access edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
        #1;
    endtask : apb
    // Halt instruction pulse, then wait for its completion
    task halt;
        @(posedge sys_clk) haltReq <= 1'b1;
        @(posedge sys_clk) haltReq <= 1'b0;
        #1;
        for (int i = 0; i < 20 && haltDone !== 1'b1; i++) @(posedge sys_clk) #1;
        `CHK(haltDone, 1'b1)
    endtask : halt
    // Wait for a wake-up pulse under a bound
    task waitWake;
        for (int i = 0; i < 20 && resumeNext !== 1'b1; i++) @(posedge sys_clk) #1;
        `CHK(resumeNext, 1'b1)
    endtask : waitWake
    // Drive the source flags and let the synchroniser settle
    task setFlags(input logic [7:0] f);
        @(posedge sys_clk) srcFlagIn <= f;
        repeat (4) @(posedge sys_clk);
    endtask : setFlags
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0; clkEn = 1'b1; haltReq = 1'b0; wdtTimeout = 1'b0; srcFlagIn = 8'h00;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        // Reset state, unmapped access
        apb(1'b0, REG_STAT, 32'h0);
        `CHK(rd, 32'h0000_0003)
        apb(1'b0, 8'h18, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0000_0000)
        // Pending enabled flag before halt: no-op
        apb(1'b1, REG_SRC_EN, 32'h0000_0001);
        setFlags(8'h01);
        halt;
        `CHK(haltNop, 1'b1)
        `CHK(wdtClear, 1'b0)
        `CHK(halted, 1'b0)
        apb(1'b0, REG_STAT, 32'h0);
        `CHK(rd, 32'h0000_0003)
        // Real halt, flag arrives afterwards, global enable clear
        setFlags(8'h00);
        halt;
        `CHK(haltNop, 1'b0)
        `CHK(wdtClear, 1'b1)
        `CHK(halted, 1'b1)
        apb(1'b0, REG_STAT, 32'h0);
        `CHK(rd, 32'h0000_0005)
        @(posedge sys_clk) srcFlagIn <= 8'h01;
        waitWake;
        `CHK(wdtClear, 1'b1)
        `CHK(vectorReq, 1'b0)
        `CHK(halted, 1'b0)
        // Interrupt status, mask and clear
        apb(1'b0, REG_IRQ_STAT, 32'h0);
        `CHK(rd, 32'h0000_0003)
        apb(1'b1, REG_IRQ_MASK, 32'h0000_0001);
        `CHK(irq, 1'b1)
        apb(1'b1, REG_IRQ_STAT, 32'h0000_0003);
        `CHK(irq, 1'b0)
        // Disabled source cannot wake; watchdog wake clears timeout
        apb(1'b1, REG_SRC_EN, 32'h0000_0000);
        setFlags(8'h02);
        halt;
        `CHK(haltNop, 1'b0)
        repeat (10) @(posedge sys_clk);
        `CHK(halted, 1'b1)
        @(posedge sys_clk) wdtTimeout <= 1'b1;
        waitWake;
        `CHK(wdtClear, 1'b1)
        `CHK(vectorReq, 1'b0)
        @(posedge sys_clk) wdtTimeout <= 1'b0;
        apb(1'b0, REG_STAT, 32'h0);
        `CHK(rd, 32'h0000_0000)
        // Global enable set: wake then vector
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        apb(1'b0, REG_CTRL, 32'h0);
        `CHK(rd, 32'h0000_0001)
        apb(1'b1, REG_SRC_EN, 32'h0000_0008);
        setFlags(8'h00);
        halt;
        @(posedge sys_clk) srcFlagIn <= 8'h08;
        waitWake;
        `CHK(vectorReq, 1'b1)
        `CHK(vectorAddr, IRQ_VECTOR)
        test_done;
    end
endmodule : sleep_wake_control_bench
